// file: avp_pkg.sv
package avp_pkg;

  // ***************************************************************
  // register map and field layout
  // ***************************************************************
  localparam logic [7:0] CFG_ADDR = 8'hb1;
  localparam int CFG_CODEC_BIT = 0;
  localparam int CFG_MODE_LSB = 1;
  localparam int CFG_SOFT_BIT = 3;
  localparam int CFG_BITS = 4;
  localparam logic [3:0] CFG_RESET = 4'h0;
  localparam int ST_ACTIVE_BIT = 15;
  localparam int ST_MEM_BIT = 14;

  // radio operating modes; the spare code behaves as idle
  localparam logic [1:0] MODE_IDLE = 2'h0;
  localparam logic [1:0] MODE_RX = 2'h1;
  localparam logic [1:0] MODE_TX = 2'h2;

  // ***************************************************************
  // sample format and timing
  // ***************************************************************
  localparam int PCM_BITS = 16;
  localparam int LLR_BITS = 4;
  localparam int REF_CLK_HZ = 25000000;
  localparam int SAMPLE_RATE_HZ = 8000;
  localparam int SAMPLE_CYC = REF_CLK_HZ / SAMPLE_RATE_HZ;
  localparam int LP_SHIFT = 2;
  localparam int BUF_DEPTH = 2;

  typedef enum logic [0:0] {
    L_IDLE = 1'b0,
    L_SHIFT = 1'b1
  } avp_link_st_t;

endpackage

// file: avp_fifo.sv
`timescale 1ns/100ps
module avp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic push, pop;

  // honest flags straight from the occupancy count
  assign in_ready_o = (cnt_q != FULL);
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem_q[rd_q];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // next pointers, count and storage
  always_comb begin
    mem_d = mem_q;
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wr_q] = in_data_i;
      wr_d = (wr_q == LAST) ? '0 : wr_q + 1'b1;
    end
    if (pop) begin
      rd_d = (rd_q == LAST) ? '0 : rd_q + 1'b1;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      mem_q <= mem_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // a stalled full buffer must keep both its count and its head word
  fifo_bound_a: assert property (@(posedge clk_i)
    disable iff (!nrst_i) (cnt_q == FULL && !out_ready_i) |=>
      (cnt_q == FULL) && $stable(out_data_o))
    else $error("buffer lost a word while stalled");
endmodule

// file: avp_port.sv
// Notes on behaviour
// - config bit 0 picks the port mode: 0 control mode (reset), 1 codec
// - codec samples are 16-bit PCM words at 8000 per second per direction
// - transmit: microphone samples lowpass filtered, shifted out to vocoder
// - receive: samples read from vocoder, filtered, sent to attenuator
// - port wires shared with boot memory; separate memory select avoids clash
// - soft output gives 4-bit likelihoods per bit, four times the data
// - half duplex: receive or transmit, never both; idle is low power
`timescale 1ns/100ps
module avp_port #(
  parameter int SAMPLE_CYC = avp_pkg::SAMPLE_CYC,
  parameter int BUF_DEPTH = avp_pkg::BUF_DEPTH
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic link_clk_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  output logic [15:0] reg_rdata_o,
  input wire logic mic_valid_i,
  input wire logic [15:0] mic_pcm_i,
  output logic audio_valid_o,
  input wire logic audio_ready_i,
  output logic [15:0] audio_pcm_o,
  input wire logic mem_req_i,
  output logic mem_grant_o,
  output logic memory_select_out_n_o,
  output logic port_chip_select_n_o,
  output logic codec_sample_out_line_o,
  input wire logic codec_sample_in_line_i,
  input wire logic demod_valid_i,
  input wire logic [3:0] demod_llr_i,
  output logic payload_valid_o,
  output logic [15:0] payload_word_o
);
  localparam int CW = $clog2(SAMPLE_CYC);
  localparam logic [CW-1:0] SAMPLE_LAST = CW'(SAMPLE_CYC - 1);
  localparam logic [4:0] WORD_BITS = 5'(avp_pkg::PCM_BITS);
  localparam logic [4:0] LLR_STEP = 5'(avp_pkg::LLR_BITS);
  localparam logic [3:0] LAST_BIT = 4'(avp_pkg::PCM_BITS - 1);

  // one-pole lowpass: y moves a quarter of the way toward x
  function automatic logic [15:0] avp_lp(input logic [15:0] y,
                                         input logic [15:0] x);
    logic signed [16:0] diff;
    logic signed [16:0] step;
    diff = $signed({x[15], x}) - $signed({y[15], y});
    step = diff >>> avp_pkg::LP_SHIFT;
    return y + step[15:0];
  endfunction

  // ***************************************************************
  // reference clock domain: control, timing and memory arbitration
  // ***************************************************************
  logic [3:0] cfg_q, cfg_d;
  logic [CW-1:0] samp_q, samp_d;
  logic act_q, act_d;
  logic req_tgl_q, req_tgl_d;
  logic [15:0] hold_q, hold_d;
  logic grant_q, grant_d;
  logic [15:0] rdata_q, rdata_d;
  logic ds1_q, ds2_q, ds3_q;
  // filter state and link done toggle are read here before their groups
  logic [15:0] lp_tx_q;
  logic done_tgl_q;
  logic codec_en, mode_rx, mode_tx, soft_en, tick, start, done_pulse;
  logic [1:0] mode;

  assign codec_en = cfg_q[avp_pkg::CFG_CODEC_BIT];
  assign mode = cfg_q[avp_pkg::CFG_MODE_LSB +: 2];
  assign soft_en = cfg_q[avp_pkg::CFG_SOFT_BIT];
  // only one direction can ever be active, the spare code idles
  assign mode_rx = (mode == avp_pkg::MODE_RX);
  assign mode_tx = (mode == avp_pkg::MODE_TX);
  assign tick = (samp_q == '0);
  assign done_pulse = ds2_q ^ ds3_q;

  logic rx_pend_q;
  // a frame waits while memory owns the wires or a word is still pending
  assign start = tick && codec_en && (mode_rx || mode_tx) && !act_q
                 && !grant_q && !rx_pend_q;

  // next values of the control group
  always_comb begin
    cfg_d = cfg_q;
    if (reg_wr_i && reg_addr_i == avp_pkg::CFG_ADDR) begin
      cfg_d = reg_wdata_i[avp_pkg::CFG_BITS-1:0];
    end
    samp_d = tick ? SAMPLE_LAST : samp_q - 1'b1;
    act_d = act_q;
    if (done_pulse) begin
      act_d = 1'b0;
    end
    if (start) begin
      act_d = 1'b1;
    end
    req_tgl_d = req_tgl_q ^ start;
    hold_d = hold_q;
    if (start) begin
      hold_d = mode_tx ? lp_tx_q : '0;
    end
    // memory gets the wires only while no codec frame is in flight
    grant_d = mem_req_i && !act_d;
    rdata_d = '0;
    if (reg_addr_i == avp_pkg::CFG_ADDR) begin
      rdata_d[avp_pkg::CFG_BITS-1:0] = cfg_q;
      rdata_d[avp_pkg::ST_ACTIVE_BIT] = act_q;
      rdata_d[avp_pkg::ST_MEM_BIT] = grant_q;
    end
  end

  // the done flag arrives from the link as a toggle, hence three stages
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg_q <= avp_pkg::CFG_RESET;
      samp_q <= SAMPLE_LAST;
      act_q <= 1'b0;
      req_tgl_q <= 1'b0;
      hold_q <= '0;
      grant_q <= 1'b0;
      rdata_q <= '0;
      ds1_q <= 1'b0;
      ds2_q <= 1'b0;
      ds3_q <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      samp_q <= samp_d;
      act_q <= act_d;
      req_tgl_q <= req_tgl_d;
      hold_q <= hold_d;
      grant_q <= grant_d;
      rdata_q <= rdata_d;
      ds1_q <= done_tgl_q;
      ds2_q <= ds1_q;
      ds3_q <= ds2_q;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign mem_grant_o = grant_q;
  assign memory_select_out_n_o = !grant_q;

  // ***************************************************************
  // audio filters, receive buffer and payload packing
  // ***************************************************************
  logic [15:0] lp_tx_d, lp_rx_q, lp_rx_d;
  logic rx_pend_d, fifo_ready;
  logic [4:0] pk_cnt_q, pk_cnt_d;
  logic [15:0] pk_word_q, pk_word_d, pay_word_q, pay_word_d;
  logic pay_valid_q, pay_valid_d;
  logic [15:0] link_word_q;

  // next values of the datapath group
  always_comb begin
    lp_tx_d = lp_tx_q;
    if (mic_valid_i) begin
      lp_tx_d = avp_lp(lp_tx_q, mic_pcm_i);
    end
    lp_rx_d = lp_rx_q;
    rx_pend_d = rx_pend_q;
    if (rx_pend_q && fifo_ready) begin
      rx_pend_d = 1'b0;
    end
    // the link word is stable once its done toggle has been seen
    if (done_pulse && mode_rx) begin
      lp_rx_d = avp_lp(lp_rx_q, link_word_q);
      rx_pend_d = 1'b1;
    end
    pk_word_d = pk_word_q;
    pk_cnt_d = pk_cnt_q;
    pay_valid_d = 1'b0;
    pay_word_d = pay_word_q;
    if (demod_valid_i) begin
      if (soft_en) begin
        pk_word_d = {pk_word_q[11:0], demod_llr_i};
        pk_cnt_d = pk_cnt_q + LLR_STEP;
      end else begin
        pk_word_d = {pk_word_q[14:0], demod_llr_i[3]};
        pk_cnt_d = pk_cnt_q + 1'b1;
      end
      if (pk_cnt_d == WORD_BITS) begin
        pay_valid_d = 1'b1;
        pay_word_d = pk_word_d;
        pk_cnt_d = '0;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lp_tx_q <= '0;
      lp_rx_q <= '0;
      rx_pend_q <= 1'b0;
      pk_cnt_q <= '0;
      pk_word_q <= '0;
      pay_word_q <= '0;
      pay_valid_q <= 1'b0;
    end else begin
      lp_tx_q <= lp_tx_d;
      lp_rx_q <= lp_rx_d;
      rx_pend_q <= rx_pend_d;
      pk_cnt_q <= pk_cnt_d;
      pk_word_q <= pk_word_d;
      pay_word_q <= pay_word_d;
      pay_valid_q <= pay_valid_d;
    end
  end

  assign payload_valid_o = pay_valid_q;
  assign payload_word_o = pay_word_q;

  // a stalled attenuator backs up into rx_pend, which holds off frames
  avp_fifo #(
    .WIDTH(avp_pkg::PCM_BITS),
    .DEPTH(BUF_DEPTH)
  ) u_rx_buf (
    .clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .in_valid_i(rx_pend_q),
    .in_ready_o(fifo_ready),
    .in_data_i(lp_rx_q),
    .out_valid_o(audio_valid_o),
    .out_ready_i(audio_ready_i),
    .out_data_o(audio_pcm_o)
  );

  // ***************************************************************
  // link clock domain: 16-bit sample frame on the codec wires
  // ***************************************************************
  avp_pkg::avp_link_st_t st_q, st_d;
  logic rs1_q, rs2_q, rs3_q;
  logic [3:0] bit_q, bit_d;
  logic [15:0] sh_q, sh_d, rsh_q, rsh_d, link_word_d;
  logic cs_n_q, cs_n_d, sout_q, sout_d;
  logic done_tgl_d;
  logic req_seen;

  assign req_seen = rs2_q ^ rs3_q;

  // hold_q is frozen while the request toggle crosses, so it is safe
  always_comb begin
    st_d = st_q;
    bit_d = bit_q;
    sh_d = sh_q;
    rsh_d = rsh_q;
    cs_n_d = cs_n_q;
    sout_d = sout_q;
    link_word_d = link_word_q;
    done_tgl_d = done_tgl_q;
    unique case (st_q)
      avp_pkg::L_IDLE: begin
        if (req_seen) begin
          st_d = avp_pkg::L_SHIFT;
          sh_d = hold_q;
          sout_d = hold_q[15];
          cs_n_d = 1'b0;
          bit_d = '0;
        end
      end
      avp_pkg::L_SHIFT: begin
        rsh_d = {rsh_q[14:0], codec_sample_in_line_i};
        if (bit_q == LAST_BIT) begin
          st_d = avp_pkg::L_IDLE;
          cs_n_d = 1'b1;
          link_word_d = rsh_d;
          done_tgl_d = !done_tgl_q;
        end else begin
          bit_d = bit_q + 1'b1;
          sout_d = sh_q[14];
          sh_d = {sh_q[14:0], 1'b0};
        end
      end
    endcase
  end

  always_ff @(posedge link_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q <= avp_pkg::L_IDLE;
      rs1_q <= 1'b0;
      rs2_q <= 1'b0;
      rs3_q <= 1'b0;
      bit_q <= '0;
      sh_q <= '0;
      rsh_q <= '0;
      cs_n_q <= 1'b1;
      sout_q <= 1'b0;
      link_word_q <= '0;
      done_tgl_q <= 1'b0;
    end else begin
      st_q <= st_d;
      rs1_q <= req_tgl_q;
      rs2_q <= rs1_q;
      rs3_q <= rs2_q;
      bit_q <= bit_d;
      sh_q <= sh_d;
      rsh_q <= rsh_d;
      cs_n_q <= cs_n_d;
      sout_q <= sout_d;
      link_word_q <= link_word_d;
      done_tgl_q <= done_tgl_d;
    end
  end

  assign port_chip_select_n_o = cs_n_q;
  assign codec_sample_out_line_o = sout_q;

  // ***************************************************************
  // checks
  // ***************************************************************
  sel_exclusive_a: assert property (@(posedge ref_clk_i)
    disable iff (!nrst_i) !(grant_q && act_q))
    else $error("memory and codec selected together");
  // a frame that ends in this cycle frees the wires for a waiting memory request
  mem_wait_a: assert property (@(posedge ref_clk_i)
    disable iff (!nrst_i) (mem_req_i && act_q && !done_pulse) |=> !grant_q)
    else $error("memory granted during codec frame");
  mode_gate_a: assert property (@(posedge ref_clk_i)
    disable iff (!nrst_i) start |-> (codec_en && !grant_q) ##1 act_q)
    else $error("frame started outside codec mode");
  sample_rate_a: assert property (@(posedge ref_clk_i)
    disable iff (!nrst_i)
    tick |=> (samp_q == SAMPLE_LAST) ##1 (samp_q == SAMPLE_LAST - 1'b1))
    else $error("sample period counter off");
  half_duplex_a: assert property (@(posedge ref_clk_i)
    disable iff (!nrst_i) start |-> (mode_rx ^ mode_tx))
    else $error("frame started with no single direction");
  tx_capture_a: assert property (@(posedge ref_clk_i)
    disable iff (!nrst_i) (start && mode_tx) |=>
      (hold_q == $past(lp_tx_q)) && (req_tgl_q != $past(req_tgl_q)))
    else $error("transmit sample not captured");
  rx_deliver_a: assert property (@(posedge ref_clk_i)
    disable iff (!nrst_i) (done_pulse && mode_rx) |=> rx_pend_q && !act_q)
    else $error("received sample not queued");
  soft_pack_a: assert property (@(posedge ref_clk_i)
    disable iff (!nrst_i)
    (demod_valid_i && soft_en && pk_cnt_q == 5'd12) |=>
      payload_valid_o && payload_word_o[3:0] == $past(demod_llr_i))
    else $error("soft word not delivered after four values");
  frame_len_a: assert property (@(posedge link_clk_i)
    disable iff (!nrst_i) $fell(cs_n_q) |-> ##15 !cs_n_q ##1 cs_n_q)
    else $error("codec frame is not 16 clocks");
endmodule

// file: avp_codec_model.sv
`timescale 1ns/100ps
// ***************************************************************
// vocoder side of the codec sample link
// ***************************************************************
module avp_codec_model (
  input wire logic link_clk_i,
  input wire logic cs_n_i,
  input wire logic sdo_i,
  output logic sdi_o,
  input wire logic [15:0] send_i,
  output logic [15:0] got_o,
  output int frames_o
);
  logic [15:0] sh_q;
  int bit_q;

  initial begin
    sdi_o = 1'b0;
    got_o = 16'h0000;
    sh_q = 16'h0000;
    frames_o = 0;
    bit_q = 0;
  end

  // bits move on the falling edge so the device samples them settled
  always @(negedge link_clk_i) begin
    if (!cs_n_i) begin
      sdi_o <= send_i[15 - bit_q];
      sh_q <= {sh_q[14:0], sdo_i};
      if (bit_q == 15) begin
        got_o <= {sh_q[14:0], sdo_i};
        frames_o <= frames_o + 1;
        bit_q <= 0;
      end else begin
        bit_q <= bit_q + 1;
      end
    end else begin
      // released line toggles so a stale level never reads as data
      sdi_o <= ~sdi_o;
      bit_q <= 0;
    end
  end
endmodule

// file: aux_vocoder_pcm_port_test.sv
`timescale 1ns/100ps
module aux_vocoder_pcm_port_test;
  logic ref_clk_i, nrst_i, link_clk_i, reg_wr_i, mic_valid_i;
  logic audio_ready_i, mem_req_i, demod_valid_i, audio_valid_o;
  logic mem_grant_o, memory_select_out_n_o, port_chip_select_n_o;
  logic codec_sample_out_line_o, codec_sample_in_line_i;
  logic payload_valid_o;
  logic [7:0] reg_addr_i;
  logic [3:0] demod_llr_i;
  logic [15:0] reg_wdata_i, reg_rdata_o, mic_pcm_i, audio_pcm_o;
  logic [15:0] payload_word_o, rd_v, voc_got, aw;
  int n_mismatch = 0;
  int check_count = 0;
  int frames;

  // short sample slot keeps the run small; frames fit well inside
  avp_port #(.SAMPLE_CYC(100)) i_dut (
    .ref_clk_i, .nrst_i, .link_clk_i, .reg_wr_i, .reg_addr_i,
    .reg_wdata_i, .reg_rdata_o, .mic_valid_i, .mic_pcm_i,
    .audio_valid_o, .audio_ready_i, .audio_pcm_o, .mem_req_i,
    .mem_grant_o, .memory_select_out_n_o, .port_chip_select_n_o,
    .codec_sample_out_line_o, .codec_sample_in_line_i,
    .demod_valid_i, .demod_llr_i, .payload_valid_o, .payload_word_o
  );

  avp_codec_model i_voc (
    .link_clk_i(link_clk_i), .cs_n_i(port_chip_select_n_o),
    .sdo_i(codec_sample_out_line_o), .sdi_o(codec_sample_in_line_i),
    .send_i(16'h6000), .got_o(voc_got), .frames_o(frames)
  );

  // ***************************************************************
  // clocks, checks and bus tasks
  // ***************************************************************
  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  // link clock offset so its edges never line up with the system clock
  initial begin
    link_clk_i = 1'b0;
    #7;
    forever #16 link_clk_i = ~link_clk_i;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic test_done;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic hang(input string what);
    n_mismatch++;
    $display("Error %0t: timeout %s", $time, what);
    test_done();
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    repeat (2) @(posedge ref_clk_i);
    #1 d = reg_rdata_o;
  endtask

  task automatic wait_frames(input int n);
    int f;
    int t;
    f = frames;
    t = 0;
    while (frames < f + n && t < 200 * n) begin
      @(posedge ref_clk_i);
      t++;
    end
    if (frames < f + n) hang("frame");
  endtask

  task automatic get_audio(output logic [15:0] w);
    int t;
    t = 0;
    do begin
      @(posedge ref_clk_i);
      #1 t++;
    end while (audio_valid_o !== 1'b1 && t < 300);
    if (audio_valid_o !== 1'b1) hang("audio");
    w = audio_pcm_o;
  endtask

  task automatic strobe(input logic [3:0] v);
    @(posedge ref_clk_i);
    demod_valid_i <= 1'b1;
    demod_llr_i <= v;
    @(posedge ref_clk_i);
    demod_valid_i <= 1'b0;
  endtask

  task automatic get_payload(input logic [15:0] exp);
    int t;
    t = 0;
    #1;
    while (payload_valid_o !== 1'b1 && t < 3) begin
      @(posedge ref_clk_i);
      #1 t++;
    end
    chk(payload_valid_o, 1, "payload strobe");
    chk(payload_word_o, exp, "payload word");
  endtask

  // memory and codec selects must never be low together
  always @(negedge ref_clk_i) begin
    if (!memory_select_out_n_o) begin
      chk(port_chip_select_n_o, 1, "select overlap");
    end
  end

  // ***************************************************************
  // scenarios
  // ***************************************************************
  task automatic s_reset;
    chk(port_chip_select_n_o, 1, "codec select idle");
    chk(memory_select_out_n_o, 1, "memory select idle");
    chk(payload_valid_o, 0, "payload idle");
    rd(8'hb1, rd_v);
    chk(rd_v, 16'h0000, "config reset");
    mem_req_i <= 1'b1;
    @(posedge ref_clk_i);
    #1 chk(mem_grant_o, 1, "grant");
    chk(memory_select_out_n_o, 0, "memory select");
    @(posedge ref_clk_i);
    mem_req_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    #1 chk(memory_select_out_n_o, 1, "memory release");
  endtask

  task automatic s_regs;
    wr(8'hb0, 16'hffff);
    rd(8'hb1, rd_v);
    chk(rd_v, 16'h0000, "stray write");
    rd(8'hb0, rd_v);
    chk(rd_v, 16'h0000, "unmapped read");
    wr(8'hb1, 16'hfff8);
    rd(8'hb1, rd_v);
    chk(rd_v, 16'h0008, "config write");
  endtask

  task automatic s_ctrl;
    int f;
    wr(8'hb1, 16'h0004);
    f = frames;
    repeat (300) @(posedge ref_clk_i) mic_valid_i <= ~mic_valid_i;
    chk(16'(frames - f), 0, "frames in control mode");
    // the spare radio mode must behave as idle even in codec mode
    wr(8'hb1, 16'h0007);
    f = frames;
    repeat (300) @(posedge ref_clk_i);
    chk(16'(frames - f), 0, "frames in spare mode");
  endtask

  task automatic s_tx;
    int f;
    wr(8'hb1, 16'h0005);
    mic_pcm_i <= 16'h4000;
    repeat (100) @(posedge ref_clk_i) mic_valid_i <= ~mic_valid_i;
    wait_frames(2);
    chk(voc_got, 16'h3ffd, "tx sample");
    chk(audio_valid_o, 0, "rx while tx");
    wait_frames(1);
    f = frames;
    repeat (2050) @(posedge ref_clk_i);
    chk(16'(frames - f), 20, "sample rate");
  endtask

  task automatic s_rx;
    int f;
    wr(8'hb1, 16'h0003);
    audio_ready_i <= 1'b1;
    wait_frames(45);
    chk(voc_got, 16'h0000, "tx while rx");
    get_audio(aw);
    chk(aw, 16'h5ffd, "rx sample");
    @(posedge ref_clk_i);
    audio_ready_i <= 1'b0;
    wait_frames(3);
    f = frames;
    repeat (500) @(posedge ref_clk_i);
    chk(16'(frames - f), 0, "held off when full");
    audio_ready_i <= 1'b1;
    repeat (3) begin
      get_audio(aw);
      chk(aw, 16'h5ffd, "drained sample");
    end
  endtask

  task automatic s_mem;
    int f;
    int t;
    mem_req_i <= 1'b1;
    t = 0;
    do begin
      @(posedge ref_clk_i);
      #1 t++;
    end while (mem_grant_o !== 1'b1 && t < 100);
    if (mem_grant_o !== 1'b1) hang("grant");
    rd(8'hb1, rd_v);
    chk(rd_v, 16'h4003, "grant status");
    f = frames;
    repeat (400) @(posedge ref_clk_i);
    chk(16'(frames - f), 0, "frame while granted");
    mem_req_i <= 1'b0;
    wait_frames(1);
  endtask

  task automatic s_payload;
    logic [15:0] hw;
    hw = 16'ha5c3;
    wr(8'hb1, 16'h0000);
    for (int i = 15; i >= 0; i--) begin
      strobe({hw[i], 3'h0});
    end
    get_payload(hw);
    wr(8'hb1, 16'h0008);
    strobe(4'h1);
    strobe(4'h9);
    strobe(4'h7);
    strobe(4'he);
    get_payload(16'h197e);
  endtask

  initial begin
    nrst_i = 1'b0;
    reg_wr_i = 1'b0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 16'h0000;
    mic_valid_i = 1'b0;
    mic_pcm_i = 16'h0000;
    audio_ready_i = 1'b0;
    mem_req_i = 1'b0;
    demod_valid_i = 1'b0;
    demod_llr_i = 4'h0;
    repeat (5) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    s_reset();
    s_regs();
    s_ctrl();
    s_tx();
    s_rx();
    s_mem();
    s_payload();
    test_done();
  end
endmodule
